// >>> host_port_pkg.sv
// Purpose: Shared constants and carriers for the converter host port.
// Assumes: pclk runs at 250 MHz; registers are reached over APB.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package host_port_pkg;

  localparam int unsigned PCLK_MHZ        = 250;
  localparam int unsigned NUM_CHANNELS    = 8;
  localparam int unsigned WORD_W          = 16;
  localparam int unsigned IDX_W           = 3;

  // Reset pulse qualification and conversion time, in nanoseconds.
  localparam int unsigned PARTIAL_MIN_NS  = 40;
  localparam int unsigned FULL_MIN_NS     = 1200;
  localparam int unsigned CONV_TIME_NS    = 1000;
  localparam int unsigned PARTIAL_CYCLES  = (PARTIAL_MIN_NS * PCLK_MHZ + 999) / 1000;
  localparam int unsigned FULL_CYCLES     = (FULL_MIN_NS * PCLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_CYCLES     = (CONV_TIME_NS * PCLK_MHZ) / 1000;
  localparam int unsigned CNT_W           = 12;

  // Register map.
  localparam logic [7:0] CTRL_ADDR        = 8'h00;
  localparam logic [7:0] STATUS_ADDR      = 8'h04;
  localparam logic [7:0] PAR_WR_ADDR      = 8'h08;
  localparam logic [7:0] SER_WR_ADDR      = 8'h0C;
  localparam logic [7:0] RESULT_BASE      = 8'h20;
  localparam logic [7:0] RESULT_LAST      = 8'h3C;

  // Field positions.
  localparam int unsigned CTRL_SW_MODE    = 0;
  localparam int unsigned CTRL_FOUR_LANE  = 1;
  localparam int unsigned ST_BUSY         = 0;
  localparam int unsigned ST_REF_EN       = 1;
  localparam int unsigned ST_SERIAL_SEL   = 2;
  localparam int unsigned ST_FULL_RST     = 3;
  localparam int unsigned ST_PARTIAL_RST  = 4;

  localparam logic [1:0] CTRL_RESET       = 2'h0;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

  // Serial lane positions on the data bus.
  localparam int unsigned LANE_A_BIT      = 7;
  localparam int unsigned LANE_B_BIT      = 8;
  localparam int unsigned LANE_C_BIT      = 9;
  localparam int unsigned LANE_D_BIT      = 10;
  localparam int unsigned SERIAL_IN_BIT   = 11;
  localparam int unsigned SER_CNT_W       = 6;

  typedef struct packed {
    logic reset_pin;
    logic conversion_start;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic interface_select;
    logic ref_select;
  } ctl_pins_t;

  // Idle pin levels, so that no false edge follows reset.
  localparam ctl_pins_t PINS_IDLE = 7'h1C;

  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } serial_lanes_t;

  typedef enum logic [1:0] {
    RST_IDLE,
    RST_PULSE
  } rst_state_t;

endpackage

// >>> host_port.sv
// Purpose: Host-facing pin logic of an eight-channel simultaneous-sampling converter.
// Assumes: Control pins are asynchronous to pclk; sclk is the host's serial clock.
// Notes: Control pins pass a two-flop synchroniser before pclk logic reads them; raw cs_n resets the link domain except sin_word_ff and sin_tgl_ff.
module host_port (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  input  wire logic                        sclk,
  input  wire host_port_pkg::ctl_pins_t    pins,
  input  wire logic [15:0]                 parallel_data_bus_i,
  output logic [15:0]                      parallel_data_bus_o,
  output logic [15:0]                      parallel_data_bus_oe,
  output host_port_pkg::serial_lanes_t     serial_lanes,
  output host_port_pkg::serial_lanes_t     serial_lanes_oe,
  output logic                             busy,
  output logic                             first_channel_flag,
  output logic                             internal_ref_en
);

  host_port_pkg::ctl_pins_t    pins_meta_ff;
  host_port_pkg::ctl_pins_t    pins_ff;
  host_port_pkg::ctl_pins_t    pins_prev_ff;
  logic [15:0]                 db_meta_ff;
  logic [15:0]                 db_ff;
  logic [1:0]                  ctrl_ff;
  logic [15:0]                 result_ff [host_port_pkg::NUM_CHANNELS];
  logic [15:0]                 par_wr_ff;
  logic [15:0]                 ser_wr_ff;
  logic                        busy_ff;
  logic [host_port_pkg::CNT_W-1:0] conv_cnt_ff;
  logic [host_port_pkg::CNT_W-1:0] rst_cnt_ff;
  host_port_pkg::rst_state_t   rst_state_ff;
  logic                        full_rst_ff;
  logic                        partial_rst_ff;
  logic                        do_full;
  logic                        do_partial;
  logic [host_port_pkg::IDX_W-1:0] rd_idx_ff;
  logic                        par_first_ff;
  logic                        first_ff;
  logic                        ref_en_ff;
  logic                        pready_ff;
  logic [31:0]                 prdata_ff;
  logic                        pslverr_ff;
  logic [15:0]                 db_o_ff;
  logic [15:0]                 db_oe_ff;
  logic                        ser_first_meta_ff;
  logic                        ser_first_ff;
  logic [2:0]                  sin_tgl_sync_ff;
  logic                        serial_sel;
  logic                        sw_mode;
  logic                        four_lane;
  logic                        apb_done;
  logic                        cs_active;
  logic                        rd_fall;
  logic                        rd_rise;
  logic                        wr_rise;
  logic                        conv_rise;
  logic                        result_hit;
  logic [2:0]                  result_sel;
  logic [31:0]                 rd_value;
  logic                        rd_err;

  // Link-domain signals.
  logic                        frame_rst_n;
  logic [1:0]                  lk_mode_ff;
  logic [host_port_pkg::SER_CNT_W-1:0] bit_cnt_ff;
  host_port_pkg::serial_lanes_t lanes_ff;
  host_port_pkg::serial_lanes_t lanes_oe_ff;
  logic                        lk_first_ff;
  logic [15:0]                 sin_shift_ff;
  logic [3:0]                  sin_cnt_ff;
  logic [15:0]                 sin_word_ff;
  logic                        sin_tgl_ff;
  logic [1:0]                  wsel_two;
  logic [1:0]                  wsel_four;
  logic [3:0]                  bsel;

  assign serial_sel = pins_ff.interface_select;
  assign sw_mode    = ctrl_ff[host_port_pkg::CTRL_SW_MODE];
  assign four_lane  = ctrl_ff[host_port_pkg::CTRL_FOUR_LANE];
  assign apb_done   = psel & penable & pready_ff;
  assign cs_active  = ~pins_ff.cs_n;
  assign rd_fall    = pins_prev_ff.rd_n & ~pins_ff.rd_n;
  assign rd_rise    = ~pins_prev_ff.rd_n & pins_ff.rd_n;
  assign wr_rise    = ~pins_prev_ff.wr_n & pins_ff.wr_n;
  assign conv_rise  = ~pins_prev_ff.conversion_start & pins_ff.conversion_start;
  assign result_hit = (paddr >= host_port_pkg::RESULT_BASE) && (paddr <= host_port_pkg::RESULT_LAST)
                      && (paddr[1:0] == 2'h0);
  assign result_sel = paddr[4:2];

  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta_ff <= host_port_pkg::PINS_IDLE;
      pins_ff      <= host_port_pkg::PINS_IDLE;
      pins_prev_ff <= host_port_pkg::PINS_IDLE;
      db_meta_ff   <= host_port_pkg::WORD_ZERO;
      db_ff        <= host_port_pkg::WORD_ZERO;
    end else begin
      pins_meta_ff <= pins;
      pins_ff      <= pins_meta_ff;
      pins_prev_ff <= pins_ff;
      db_meta_ff   <= parallel_data_bus_i;
      db_ff        <= db_meta_ff;
    end
  end

  // Reset pulse length measurement and classification.
  assign do_full    = (rst_state_ff == host_port_pkg::RST_PULSE) && !pins_ff.reset_pin
                      && (rst_cnt_ff >= host_port_pkg::CNT_W'(host_port_pkg::FULL_CYCLES));
  assign do_partial = (rst_state_ff == host_port_pkg::RST_PULSE) && !pins_ff.reset_pin && !do_full
                      && (rst_cnt_ff >= host_port_pkg::CNT_W'(host_port_pkg::PARTIAL_CYCLES));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_state_ff   <= host_port_pkg::RST_IDLE;
      rst_cnt_ff     <= '0;
      full_rst_ff    <= 1'b0;
      partial_rst_ff <= 1'b0;
    end else begin
      case (rst_state_ff)
        host_port_pkg::RST_IDLE: begin
          rst_cnt_ff <= '0;
          if (pins_ff.reset_pin) begin
            rst_state_ff <= host_port_pkg::RST_PULSE;
          end
        end
        host_port_pkg::RST_PULSE: begin
          if (!pins_ff.reset_pin) begin
            rst_state_ff <= host_port_pkg::RST_IDLE;
            if (do_full) begin
              full_rst_ff    <= 1'b1;
              partial_rst_ff <= 1'b0;
            end else if (do_partial) begin
              partial_rst_ff <= 1'b1;
            end
          end else if (rst_cnt_ff != {host_port_pkg::CNT_W{1'b1}}) begin
            rst_cnt_ff <= rst_cnt_ff + 1'b1;
          end
        end
        default: begin
          rst_state_ff <= host_port_pkg::RST_IDLE;
        end
      endcase
    end
  end

  // Control register; a full reset returns it to defaults.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= host_port_pkg::CTRL_RESET;
    end else if (do_full) begin
      ctrl_ff <= host_port_pkg::CTRL_RESET;
    end else if (apb_done && pwrite && paddr == host_port_pkg::CTRL_ADDR) begin
      ctrl_ff <= pwdata[1:0];
    end
  end

  // Result words; software loads them, a full reset clears them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < host_port_pkg::NUM_CHANNELS; i++) begin
        result_ff[i] <= host_port_pkg::WORD_ZERO;
      end
    end else if (do_full) begin
      for (int i = 0; i < host_port_pkg::NUM_CHANNELS; i++) begin
        result_ff[i] <= host_port_pkg::WORD_ZERO;
      end
    end else if (apb_done && pwrite && result_hit) begin
      result_ff[result_sel] <= pwdata[15:0];
    end
  end

  // Busy follows the conversion-start edge and the conversion timer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff     <= 1'b0;
      conv_cnt_ff <= '0;
    end else if (do_full || do_partial) begin
      busy_ff     <= 1'b0;
      conv_cnt_ff <= '0;
    end else if (conv_rise && !busy_ff) begin
      busy_ff     <= 1'b1;
      conv_cnt_ff <= host_port_pkg::CNT_W'(host_port_pkg::CONV_CYCLES - 1);
    end else if (busy_ff) begin
      if (conv_cnt_ff == '0) begin
        busy_ff <= 1'b0;
      end else begin
        conv_cnt_ff <= conv_cnt_ff - 1'b1;
      end
    end
  end

  // Parallel read sequencing and bus drive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_idx_ff    <= '0;
      db_o_ff      <= host_port_pkg::WORD_ZERO;
      db_oe_ff     <= host_port_pkg::WORD_ZERO;
      par_first_ff <= 1'b0;
    end else if (!cs_active || serial_sel || do_full || do_partial || conv_rise) begin
      rd_idx_ff    <= '0;
      db_oe_ff     <= host_port_pkg::WORD_ZERO;
      par_first_ff <= 1'b0;
    end else if (rd_fall) begin
      db_o_ff      <= result_ff[rd_idx_ff];
      db_oe_ff     <= ~host_port_pkg::WORD_ZERO;
      par_first_ff <= (rd_idx_ff == '0);
    end else if (rd_rise) begin
      db_oe_ff     <= host_port_pkg::WORD_ZERO;
      par_first_ff <= 1'b0;
      rd_idx_ff    <= rd_idx_ff + 1'b1;
    end
  end

  // Parallel register write, honoured only in software mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_wr_ff <= host_port_pkg::WORD_ZERO;
    end else if (do_full) begin
      par_wr_ff <= host_port_pkg::WORD_ZERO;
    end else if (wr_rise && cs_active && !serial_sel && sw_mode && pins_ff.rd_n) begin
      par_wr_ff <= db_ff;
    end
  end

  // Serial input words arrive with a toggle from the link domain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_tgl_sync_ff <= 3'h0;
      ser_wr_ff       <= host_port_pkg::WORD_ZERO;
    end else begin
      sin_tgl_sync_ff <= {sin_tgl_sync_ff[1:0], sin_tgl_ff};
      if (do_full) begin
        ser_wr_ff <= host_port_pkg::WORD_ZERO;
      end else if (sin_tgl_sync_ff[2] != sin_tgl_sync_ff[1]) begin
        ser_wr_ff <= sin_word_ff;
      end
    end
  end

  // First-channel flag merges the parallel and the synchronised serial flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_first_meta_ff <= 1'b0;
      ser_first_ff      <= 1'b0;
      first_ff          <= 1'b0;
      ref_en_ff         <= 1'b0;
    end else begin
      ser_first_meta_ff <= lk_first_ff;
      ser_first_ff      <= ser_first_meta_ff;
      first_ff          <= par_first_ff | (ser_first_ff & serial_sel & cs_active);
      ref_en_ff         <= pins_ff.ref_select;
    end
  end

  // APB read mux.
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_err   = 1'b0;
    if (result_hit) begin
      rd_value = {16'h0000, result_ff[result_sel]};
    end else begin
      case (paddr)
        host_port_pkg::CTRL_ADDR: rd_value = {30'h0000_0000, ctrl_ff};
        host_port_pkg::STATUS_ADDR: begin
          rd_value[host_port_pkg::ST_BUSY]        = busy_ff;
          rd_value[host_port_pkg::ST_REF_EN]      = ref_en_ff;
          rd_value[host_port_pkg::ST_SERIAL_SEL]  = serial_sel;
          rd_value[host_port_pkg::ST_FULL_RST]    = full_rst_ff;
          rd_value[host_port_pkg::ST_PARTIAL_RST] = partial_rst_ff;
        end
        host_port_pkg::PAR_WR_ADDR: rd_value = {16'h0000, par_wr_ff};
        host_port_pkg::SER_WR_ADDR: rd_value = {16'h0000, ser_wr_ff};
        default: rd_err = 1'b1;
      endcase
    end
  end

  // APB slave: one wait state, then a registered answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && penable && !pready_ff) begin
      pready_ff  <= 1'b1;
      prdata_ff  <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr_ff <= rd_err;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // Link domain: serial shift-out and shift-in on the host's clock.
  assign frame_rst_n = presetn & ~pins.cs_n;
  assign wsel_two    = bit_cnt_ff[5:4];
  assign wsel_four   = {1'b0, bit_cnt_ff[4]};
  assign bsel        = 4'hF - bit_cnt_ff[3:0];

  // Link mode is set before a frame opens and stays still while sclk runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk_mode_ff <= 2'h0;
    end else begin
      lk_mode_ff <= {serial_sel, four_lane & sw_mode};
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_ff  <= '0;
      lanes_ff    <= '0;
      lanes_oe_ff <= '0;
      lk_first_ff <= 1'b0;
    end else if (lk_mode_ff[1]) begin
      bit_cnt_ff    <= bit_cnt_ff + 1'b1;
      lanes_oe_ff.a <= 1'b1;
      lanes_oe_ff.b <= 1'b1;
      lanes_oe_ff.c <= lk_mode_ff[0];
      lanes_oe_ff.d <= lk_mode_ff[0];
      if (lk_mode_ff[0]) begin
        lanes_ff.a  <= result_ff[3'(wsel_four)][bsel];
        lanes_ff.b  <= result_ff[3'(wsel_four) + 3'h2][bsel];
        lanes_ff.c  <= result_ff[3'(wsel_four) + 3'h4][bsel];
        lanes_ff.d  <= result_ff[3'(wsel_four) + 3'h6][bsel];
        lk_first_ff <= (bit_cnt_ff[4] == 1'b0);
      end else begin
        lanes_ff.a  <= result_ff[3'(wsel_two)][bsel];
        lanes_ff.b  <= result_ff[3'(wsel_two) + 3'h4][bsel];
        lanes_ff.c  <= 1'b0;
        lanes_ff.d  <= 1'b0;
        lk_first_ff <= (bit_cnt_ff[5:4] == 2'h0);
      end
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sin_shift_ff <= host_port_pkg::WORD_ZERO;
      sin_cnt_ff   <= 4'h0;
    end else if (lk_mode_ff[1]) begin
      sin_shift_ff <= {sin_shift_ff[14:0], parallel_data_bus_i[host_port_pkg::SERIAL_IN_BIT]};
      sin_cnt_ff   <= sin_cnt_ff + 1'b1;
    end
  end

  // Completed input word is held stable while its toggle crosses.
  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      sin_word_ff <= host_port_pkg::WORD_ZERO;
      sin_tgl_ff  <= 1'b0;
    end else if (lk_mode_ff[1] && sin_cnt_ff == 4'hF) begin
      sin_word_ff <= {sin_shift_ff[14:0], parallel_data_bus_i[host_port_pkg::SERIAL_IN_BIT]};
      sin_tgl_ff  <= ~sin_tgl_ff;
    end
  end

  assign pready               = pready_ff;
  assign prdata               = prdata_ff;
  assign pslverr              = pslverr_ff;
  assign parallel_data_bus_o  = db_o_ff;
  assign parallel_data_bus_oe = db_oe_ff;
  assign serial_lanes         = lanes_ff;
  assign serial_lanes_oe      = lanes_oe_ff;
  assign busy                 = busy_ff;
  assign first_channel_flag   = first_ff;
  assign internal_ref_en      = ref_en_ff;

endmodule

// >>> host_port_asserts.sv
// Purpose: Concurrent checks on the host port pins and register bus.
// Assumes: Pin inputs reach the logic through a short synchroniser.
// Notes: Busy length is counted in helper logic.
module host_port_asserts (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire host_port_pkg::ctl_pins_t      pins,
  input wire logic [15:0]                   parallel_data_bus_oe,
  input wire host_port_pkg::serial_lanes_t  serial_lanes_oe,
  input wire logic                          busy,
  input wire logic                          internal_ref_en
);
  int busy_cnt_ff;

  // Counts the cycles busy has been high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= busy ? busy_cnt_ff + 1 : 0;
    end
  end

  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not after one wait state");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_busy_follows_start: assert property ($rose(pins.conversion_start) && !busy |-> ##[1:5] busy)
    else $error("busy did not follow start");
  a_busy_length: assert property ($fell(busy) |-> busy_cnt_ff inside {[249:251]})
    else $error("busy length wrong");
  a_bus_float_idle: assert property ((pins.cs_n && $past(pins.cs_n, 4)) || (pins.rd_n && $past(pins.rd_n, 4))
    |-> parallel_data_bus_oe == 16'h0000)
    else $error("bus driven while idle");
  a_bus_whole_word: assert property (parallel_data_bus_oe == 16'h0000 || parallel_data_bus_oe == 16'hFFFF)
    else $error("bus partly driven");
  a_serial_no_bus: assert property (pins.interface_select && $past(pins.interface_select, 4)
    |-> parallel_data_bus_oe == 16'h0000)
    else $error("bus driven in serial mode");
  a_lanes_cd_pair: assert property (serial_lanes_oe.c |-> serial_lanes_oe.d && serial_lanes_oe.a)
    else $error("lane c without d and a");
  a_ref_on: assert property ($rose(pins.ref_select) |-> ##[2:4] internal_ref_en)
    else $error("reference not enabled");
  a_ref_off: assert property ($fell(pins.ref_select) |-> ##[2:4] !internal_ref_en)
    else $error("reference not disabled");
endmodule

bind host_port host_port_asserts port_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .pins(pins),
  .parallel_data_bus_oe(parallel_data_bus_oe),
  .serial_lanes_oe(serial_lanes_oe),
  .busy(busy),
  .internal_ref_en(internal_ref_en)
);

// >>> host_model.sv
// Purpose: Host that clocks serial frames and captures the lanes.
// Assumes: Chip select is framed by the testbench.
// Notes: Clock idles low between frames.
module host_model (
  input wire host_port_pkg::serial_lanes_t  serial_lanes,
  output logic                              sclk,
  output logic                              serial_in,
  output logic                              serial_in_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] cap_a;
  logic [63:0] cap_b;
  logic [63:0] cap_c;
  logic [63:0] cap_d;

  initial begin
    sclk = 1'b0;
    serial_in = 1'b0;
    serial_in_en = 1'b0;
  end

  // Clocks one frame at 160 ns a bit and sends a word on the serial input.
  task automatic frame(input int nbits, input logic [15:0] word);
    #1.3;
    serial_in_en = 1'b1;
    for (int k = 0; k < nbits; k++) begin
      serial_in = word[15 - (k % 16)];
      #40 sclk = 1'b1;
      #80 sclk = 1'b0;
      #40;
      cap_a = {cap_a[62:0], serial_lanes.a};
      cap_b = {cap_b[62:0], serial_lanes.b};
      cap_c = {cap_c[62:0], serial_lanes.c};
      cap_d = {cap_d[62:0], serial_lanes.d};
    end
    serial_in_en = 1'b0;
  endtask
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench for the converter host port.
// Assumes: Pins change right after pclk edges.
// Notes: Register and parallel results are checked from queues.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]                   paddr;
  logic [31:0]                  pwdata, prdata;
  host_port_pkg::ctl_pins_t     pins_r;
  logic [15:0]                  bus_i, bus_o, bus_oe, hval, flt, pw, v;
  host_port_pkg::serial_lanes_t lanes, lanes_oe;
  logic                         hen, busy, flag, ref_en, sclk, sin, sin_en, oe_q, oe_q2;
  logic [15:0]                  res [8];
  logic [32:0]                  expq [$];
  logic [16:0]                  parq [$];
  int                           miscompares, num_checks;

  assign flt   = sin_en ? {4'h0, sin, 11'h000} : (hen ? hval : ~bus_o);
  assign bus_i = (bus_o & bus_oe) | (flt & ~bus_oe);

  host_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .sclk(sclk),
    .pins(pins_r), .parallel_data_bus_i(bus_i), .parallel_data_bus_o(bus_o), .parallel_data_bus_oe(bus_oe),
    .serial_lanes(lanes), .serial_lanes_oe(lanes_oe), .busy(busy), .first_channel_flag(flag),
    .internal_ref_en(ref_en));
  host_model host (.serial_lanes(lanes), .sclk(sclk), .serial_in(sin), .serial_in_en(sin_en));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic e);
    apb(1'b1, a, d, {e, 32'h00000000});
  endtask

  task automatic rd(logic [7:0] a, logic [32:0] e);
    apb(1'b0, a, 32'h00000000, e);
  endtask

  task automatic wait_busy(logic lvl, output int n);
    n = 0;
    while (busy !== lvl && n < 400) begin
      cyc(1);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  // Bus answers and parallel results are compared with the oldest note.
  always @(posedge pclk) begin
    oe_q <= bus_oe[0];
    oe_q2 <= oe_q;
    if (psel && penable && pready === 1'b1) begin
      chk("apb", {31'h0, pslverr, prdata}, {31'h0, expq.pop_front()});
    end
    if (bus_oe[0] === 1'b1 && oe_q === 1'b1 && oe_q2 !== 1'b1) begin
      chk("par_read", {47'h0, flag, bus_o}, {47'h0, parq.pop_front()});
    end
  end

  initial begin
    int n;
    int m;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    hen = 1'b0;
    hval = 16'h0000;
    pins_r = 7'h1D;
    presetn = 1'b0;
    void'($urandom(32'h5142EE10));
    cyc(2);
    presetn <= 1'b1;
    pins_r.reset_pin <= 1'b1;
    cyc(310);
    pins_r.reset_pin <= 1'b0;
    cyc(8);
    rd(8'h04, 33'h00000000A);
    rd(8'h10, 33'h100000000);
    wr(8'h10, 32'h00000000, 1'b1);
    $display("test registers done");
    pins_r.conversion_start <= 1'b1;
    wait_busy(1'b1, n);
    chk("busy_rise", 64'(n >= 1 && n <= 6), 64'h1);
    pins_r.conversion_start <= 1'b0;
    cyc(20);
    pins_r.conversion_start <= 1'b1;
    cyc(4);
    pins_r.conversion_start <= 1'b0;
    wait_busy(1'b0, m);
    chk("busy_len", 64'(m + 24 >= 249 && m + 24 <= 251), 64'h1);
    $display("test conversion done");
    for (int i = 0; i < 8; i++) begin
      res[i] = 16'($urandom);
      wr(8'h20 + 8'(4 * i), {16'h0000, res[i]}, 1'b0);
      rd(8'h20 + 8'(4 * i), {17'h00000, res[i]});
    end
    pins_r.cs_n <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      parq.push_back({i == 0, res[i]});
      cyc(4);
      pins_r.rd_n <= 1'b0;
      cyc(8);
      pins_r.rd_n <= 1'b1;
      cyc(8);
      chk("par_float", 64'(bus_oe), 64'h0);
    end
    pins_r.cs_n <= 1'b1;
    chk("par_count", 64'(parq.size()), 64'h0);
    $display("test parallel read done");
    pw = 16'h0000;
    for (int sw = 1; sw >= 0; sw--) begin
      wr(8'h00, 32'(sw), 1'b0);
      v = 16'($urandom);
      pw = sw ? v : pw;
      hval <= v;
      hen <= 1'b1;
      pins_r.cs_n <= 1'b0;
      cyc(4);
      pins_r.wr_n <= 1'b0;
      cyc(8);
      pins_r.wr_n <= 1'b1;
      cyc(8);
      pins_r.cs_n <= 1'b1;
      hen <= 1'b0;
      rd(8'h08, {17'h00000, pw});
    end
    $display("test parallel write done");
    pins_r.interface_select <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      wr(8'h00, f ? 32'h00000003 : 32'h00000000, 1'b0);
      v = 16'($urandom);
      cyc(4);
      pins_r.cs_n <= 1'b0;
      cyc(4);
      host.frame(f ? 32 : 64, v);
      cyc(4);
      pins_r.cs_n <= 1'b1;
      cyc(8);
      if (f) begin
        chk("lane_a4", {32'h0, host.cap_a[31:0]}, {32'h0, res[0], res[1]});
        chk("lane_b4", {32'h0, host.cap_b[31:0]}, {32'h0, res[2], res[3]});
        chk("lane_c4", {32'h0, host.cap_c[31:0]}, {32'h0, res[4], res[5]});
        chk("lane_d4", {32'h0, host.cap_d[31:0]}, {32'h0, res[6], res[7]});
      end else begin
        chk("lane_a", host.cap_a, {res[0], res[1], res[2], res[3]});
        chk("lane_b", host.cap_b, {res[4], res[5], res[6], res[7]});
      end
      rd(8'h0C, {17'h00000, v});
    end
    pins_r.interface_select <= 1'b0;
    $display("test serial done");
    for (int r = 0; r < 2; r++) begin
      pins_r.ref_select <= 1'(r);
      cyc(6);
      chk("ref_en", 64'(ref_en), 64'(r));
    end
    wr(8'h00, 32'h00000003, 1'b0);
    pins_r.reset_pin <= 1'b1;
    cyc(20);
    pins_r.reset_pin <= 1'b0;
    cyc(8);
    rd(8'h00, 33'h000000003);
    pins_r.reset_pin <= 1'b1;
    cyc(310);
    pins_r.reset_pin <= 1'b0;
    cyc(8);
    rd(8'h00, 33'h000000000);
    rd(8'h20, 33'h000000000);
    $display("test reset pin done");
    cyc(4);
    tally_and_finish();
  end

  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
endmodule
